// *** dpbr_fabric_port.sv ***
// Fabric-side driver model for one RAM port
`timescale 1ns/1ps
`default_nettype none

module dpbr_fabric_port import dpbr_pkg::*; #(
  parameter int unsigned AW = 10,
  parameter int unsigned DW = 4,
  parameter logic [3:0] INV = 4'h0
) (
  input wire logic clk_i,
  output var logic pclk_o,
  output var logic en_o,
  output var logic we_o,
  output var logic orst_o,
  output var logic [AW-1:0] addr_o,
  output var logic [DW-1:0] data_o
);
  // Idle levels at time zero, controls inactive through the inversion mask
  initial begin
    pclk_o = INV[INV_CLK];
    en_o = INV[INV_EN];
    we_o = INV[INV_WE];
    orst_o = INV[INV_RST];
    addr_o = '0;
    data_o = '0;
  end

  // One port cycle; controls lead the port edge by two system clocks
  task automatic access(input logic en, input logic we, input logic rst,
                        input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk_i);
    #1;
    en_o = en ^ INV[INV_EN];
    we_o = we ^ INV[INV_WE];
    orst_o = rst ^ INV[INV_RST];
    addr_o = a;
    data_o = d;
    repeat (2) @(posedge clk_i);
    #1 pclk_o = ~INV[INV_CLK];
    repeat (3) @(posedge clk_i);
    #1 pclk_o = INV[INV_CLK];
    repeat (2) @(posedge clk_i);
    #1;
    // Released enable goes inactive; the other lines show scrambled values, not the last ones
    en_o = INV[INV_EN];
    we_o = ~we_o;
    orst_o = ~orst_o;
    addr_o = ~a;
    data_o = ~d;
  endtask : access
endmodule : dpbr_fabric_port

`default_nettype wire

// *** dpbr_pkg.sv ***
// Shared constants and helper functions for the dual-port block RAM
package dpbr_pkg;

  // Shared array geometry
  localparam int CELL_COUNT = 4096;
  localparam int CELL_AW = 12;
  localparam int WORD_W = 16;
  localparam int WORD_AW = 8;
  localparam int NUM_WORDS = 256;
  localparam int OFF_W = 4;
  localparam int MAX_LOG2W = 4;

  // Bit positions of the control polarity vector
  localparam int INV_CLK = 3;
  localparam int INV_EN = 2;
  localparam int INV_WE = 1;
  localparam int INV_RST = 0;
  localparam int CTL_W = 4;

  // Values after reset
  localparam logic [15:0] DOUT_RST = 16'h0000;
  localparam logic SYNC_RST = 1'b0;
  localparam logic CLK_PREV_RST = 1'b1;

  // Address bus width for a port of width 2**lw
  function automatic int addr_w(input int unsigned lw);
    return CELL_AW - int'(lw);
  endfunction : addr_w

  // Data bus width for a port of width 2**lw
  function automatic int data_w(input int unsigned lw);
    return 1 << lw;
  endfunction : data_w

  // First cell covered by word a at width 2**lw
  function automatic logic [11:0] cell_base(input logic [11:0] a, input int unsigned lw);
    return 12'(a << lw);
  endfunction : cell_base

  // Low-aligned mask of one word at width 2**lw
  function automatic logic [15:0] cell_mask(input int unsigned lw);
    return 16'((32'h1 << (32'h1 << lw)) - 32'h1);
  endfunction : cell_mask

endpackage : dpbr_pkg

// *** dpbr_port_sync.sv ***
// Pin synchroniser, polarity select and active-edge detect for one RAM port
`timescale 1ns/1ps
`default_nettype none

module dpbr_port_sync import dpbr_pkg::*; #(
  parameter int unsigned AW = 12,
  parameter int unsigned DW = 1,
  parameter logic [3:0] INV = 4'h0
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic pin_clk_i,
  input wire logic pin_en_i,
  input wire logic pin_we_i,
  input wire logic pin_rst_i,
  input wire logic [AW-1:0] pin_addr_i,
  input wire logic [DW-1:0] pin_data_i,
  output logic edge_o,
  output logic en_o,
  output logic we_o,
  output logic rst_o,
  output logic [AW-1:0] addr_o,
  output logic [DW-1:0] data_o
);

  localparam int SW = CTL_W + AW + DW;

  logic [SW-1:0] s1_r;
  logic [SW-1:0] s1_nxt;
  logic [SW-1:0] s2_r;
  logic [SW-1:0] s2_nxt;
  logic clk_prev_r;
  logic clk_prev_nxt;
  logic [CTL_W-1:0] ctl;

  //////////////////////////////////////////////////////////////////////////////
  // Two-stage capture; polarity applied after the second stage
  always_comb begin
    s1_nxt = {pin_clk_i, pin_en_i, pin_we_i, pin_rst_i, pin_addr_i, pin_data_i};
    s2_nxt = s1_r;
    ctl = s2_r[SW-1 -: CTL_W] ^ INV;
    clk_prev_nxt = ctl[INV_CLK];
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s1_r <= {SW{SYNC_RST}};
      s2_r <= {SW{SYNC_RST}};
      clk_prev_r <= CLK_PREV_RST;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      clk_prev_r <= clk_prev_nxt;
    end
  end

  // Inputs seen at the same stage as the port clock edge
  assign edge_o = ctl[INV_CLK] & ~clk_prev_r;
  assign en_o = ctl[INV_EN];
  assign we_o = ctl[INV_WE];
  assign rst_o = ctl[INV_RST];
  assign addr_o = s2_r[DW +: AW];
  assign data_o = s2_r[DW-1:0];

  chk_edge_pulse: assert property (@(posedge clk_i) disable iff (reset_i)
    edge_o |=> !edge_o)
    else $error("port edge lasted more than one cycle");

endmodule : dpbr_port_sync

`default_nettype wire

// *** dpbr_top.sv ***
// Dual-port block RAM over a shared 4096-cell array with per-port aspect ratio
`timescale 1ns/1ps
`default_nettype none

module dpbr_top import dpbr_pkg::*; #(
  parameter int unsigned A_LOG2W = 2,
  parameter int unsigned B_LOG2W = 2,
  parameter bit DUAL_PORT = 1'b1,
  parameter logic [3:0] A_INV = 4'h0,
  parameter logic [3:0] B_INV = 4'h0
) (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic PCLK_A_I,
  input wire logic EN_A_I,
  input wire logic WE_A_I,
  input wire logic ORST_A_I,
  input wire logic [addr_w(A_LOG2W)-1:0] ADDR_A_I,
  input wire logic [data_w(A_LOG2W)-1:0] WRITE_DATA_IN_A_I,
  output logic [data_w(A_LOG2W)-1:0] DOUT_A_O,
  input wire logic PCLK_B_I,
  input wire logic EN_B_I,
  input wire logic WE_B_I,
  input wire logic ORST_B_I,
  input wire logic [addr_w(B_LOG2W)-1:0] ADDR_B_I,
  input wire logic [data_w(B_LOG2W)-1:0] WRITE_DATA_IN_B_I,
  output logic [data_w(B_LOG2W)-1:0] DOUT_B_O
);

  localparam int AWA = addr_w(A_LOG2W);
  localparam int DWA = data_w(A_LOG2W);
  localparam int AWB = addr_w(B_LOG2W);
  localparam int DWB = data_w(B_LOG2W);
  localparam int unsigned LW [2] = '{A_LOG2W, B_LOG2W};

  // Shared cell array, 16 cells to a word
  logic [WORD_W-1:0] mem_r [NUM_WORDS];

  logic [1:0] edge_p;
  logic [1:0] en_p;
  logic [1:0] we_p;
  logic [1:0] rst_p;
  logic [1:0] act;
  logic [1:0] wr;
  logic [AWA-1:0] addr_a;
  logic [DWA-1:0] data_a;
  logic [AWB-1:0] addr_b;
  logic [DWB-1:0] data_b;
  logic [CELL_AW-1:0] addr_ext [2];
  logic [WORD_W-1:0] wdata_ext [2];
  logic [CELL_AW-1:0] base [2];
  logic [WORD_AW-1:0] idx [2];
  logic [OFF_W-1:0] off [2];
  logic [WORD_W-1:0] msk [2];
  logic [WORD_W-1:0] wd [2];
  logic [WORD_W-1:0] rd [2];
  logic [WORD_W-1:0] word_nxt [2];
  logic [WORD_W-1:0] dout_r [2];
  logic [WORD_W-1:0] dout_nxt [2];
  logic same_word;

  //////////////////////////////////////////////////////////////////////////////
  // Pin conditioning per port
  dpbr_port_sync #(.AW(AWA), .DW(DWA), .INV(A_INV)) u_sync_a (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .pin_clk_i(PCLK_A_I),
    .pin_en_i(EN_A_I),
    .pin_we_i(WE_A_I),
    .pin_rst_i(ORST_A_I),
    .pin_addr_i(ADDR_A_I),
    .pin_data_i(WRITE_DATA_IN_A_I),
    .edge_o(edge_p[0]),
    .en_o(en_p[0]),
    .we_o(we_p[0]),
    .rst_o(rst_p[0]),
    .addr_o(addr_a),
    .data_o(data_a)
  );

  dpbr_port_sync #(.AW(AWB), .DW(DWB), .INV(B_INV)) u_sync_b (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .pin_clk_i(PCLK_B_I),
    .pin_en_i(EN_B_I),
    .pin_we_i(WE_B_I),
    .pin_rst_i(ORST_B_I),
    .pin_addr_i(ADDR_B_I),
    .pin_data_i(WRITE_DATA_IN_B_I),
    .edge_o(edge_p[1]),
    .en_o(en_p[1]),
    .we_o(we_p[1]),
    .rst_o(rst_p[1]),
    .addr_o(addr_b),
    .data_o(data_b)
  );

  // Widen both ports to the common cell geometry
  assign addr_ext[0] = CELL_AW'(addr_a);
  assign addr_ext[1] = CELL_AW'(addr_b);
  assign wdata_ext[0] = WORD_W'(data_a);
  assign wdata_ext[1] = WORD_W'(data_b);

  //////////////////////////////////////////////////////////////////////////////
  // Per-port address mapping and access qualification
  for (genvar p = 0; p < 2; p++) begin : g_port
    if (p == 0) begin : g_en_a
      assign act[p] = edge_p[p] & en_p[p];
    end else begin : g_en_b
      assign act[p] = edge_p[p] & en_p[p] & DUAL_PORT;
    end
    assign wr[p] = act[p] & we_p[p];
    assign base[p] = cell_base(addr_ext[p], LW[p]);
    assign idx[p] = base[p][CELL_AW-1 -: WORD_AW];
    assign off[p] = base[p][OFF_W-1:0];
    assign msk[p] = WORD_W'(cell_mask(LW[p]) << off[p]);
    assign wd[p] = WORD_W'(wdata_ext[p] << off[p]) & msk[p];
    assign rd[p] = WORD_W'((mem_r[idx[p]] & msk[p]) >> off[p]);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next read data and merged word writes
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      dout_nxt[p] = dout_r[p];
      if (act[p]) begin
        if (rst_p[p]) begin
          dout_nxt[p] = DOUT_RST;
        end else if (we_p[p]) begin
          dout_nxt[p] = wdata_ext[p];
        end else begin
          dout_nxt[p] = rd[p];
        end
      end
    end
    // Port B merges over port A when both hit one word; shared cells take port B data
    same_word = wr[0] && (idx[0] == idx[1]);
    word_nxt[0] = (mem_r[idx[0]] & ~msk[0]) | wd[0];
    word_nxt[1] = ((same_word ? word_nxt[0] : mem_r[idx[1]]) & ~msk[1]) | wd[1];
  end

  // Read data registers, cleared only by system reset or output reset
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      dout_r[0] <= DOUT_RST;
      dout_r[1] <= DOUT_RST;
    end else begin
      dout_r[0] <= dout_nxt[0];
      dout_r[1] <= dout_nxt[1];
    end
  end

  // Array writes; output reset does not block them
  always_ff @(posedge CLK_I) begin
    if (wr[0]) begin
      mem_r[idx[0]] <= word_nxt[0];
    end
    if (wr[1]) begin
      mem_r[idx[1]] <= word_nxt[1];
    end
  end

  assign DOUT_A_O = dout_r[0][DWA-1:0];
  assign DOUT_B_O = dout_r[1][DWB-1:0];

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [WORD_AW-1:0] probe_idx_r;
  logic [WORD_W-1:0] probe_r;

  // Snapshot of one word for the idle check
  always_ff @(posedge CLK_I) begin
    probe_idx_r <= idx[0];
    probe_r <= mem_r[idx[0]];
  end

  chk_mem_quiet: assert property (@(posedge CLK_I) disable iff (RESET_I)
    !(wr[0] || wr[1]) |=> mem_r[probe_idx_r] === probe_r)
    else $error("memory changed with no enabled write");

  chk_pairing_legal: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (A_LOG2W <= MAX_LOG2W) && (!DUAL_PORT || (B_LOG2W >= A_LOG2W && B_LOG2W <= MAX_LOG2W)))
    else $error("illegal port width pairing");

  for (genvar p = 0; p < 2; p++) begin : g_chk
    chk_hold_idle: assert property (@(posedge CLK_I) disable iff (RESET_I)
      !act[p] |=> $stable(dout_r[p]))
      else $error("read data moved while port disabled");

    chk_write_first: assert property (@(posedge CLK_I) disable iff (RESET_I)
      (act[p] && we_p[p] && !rst_p[p]) |=> dout_r[p] == $past(wdata_ext[p]))
      else $error("write data not shown on read data");

    chk_read_data: assert property (@(posedge CLK_I) disable iff (RESET_I)
      (act[p] && !we_p[p] && !rst_p[p]) |=> dout_r[p] == $past(rd[p]))
      else $error("read data does not match addressed cells");

    chk_out_reset: assert property (@(posedge CLK_I) disable iff (RESET_I)
      (act[p] && rst_p[p]) |=> dout_r[p] == DOUT_RST)
      else $error("output reset did not clear read data");

    chk_write_stores: assert property (@(posedge CLK_I) disable iff (RESET_I)
      (wr[p] && !(p == 0 && wr[1] && idx[0] == idx[1] && (msk[0] & msk[1]) != 16'h0000))
      |=> (mem_r[$past(idx[p])] & $past(msk[p])) == $past(wd[p]))
      else $error("enabled write not stored");
  end

endmodule : dpbr_top

`default_nettype wire

// *** test_dual_port_block_ram.sv ***
// Self-checking bench for the dual-port block RAM, x4 port A and inverted x16 port B
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %0t got %h expected %h", $time, (g), (e)); end end

module test_dual_port_block_ram;
  logic clk;
  logic rst;
  int miscompares = 0;
  int samples_checked = 0;
  wire logic pclk_a, en_a, we_a, orst_a, pclk_b, en_b, we_b, orst_b;
  wire logic [9:0] addr_a;
  wire logic [3:0] wd_a;
  wire logic [3:0] dout_a;
  wire logic [7:0] addr_b;
  wire logic [15:0] wd_b;
  wire logic [15:0] dout_b;

  ////////////////////////////////////////////////////////////////////////
  // Clock, fabric models and device
  initial clk = 1'b0;
  always #10 clk = ~clk;

  dpbr_fabric_port u_pa (.clk_i(clk), .pclk_o(pclk_a), .en_o(en_a),
    .we_o(we_a), .orst_o(orst_a), .addr_o(addr_a), .data_o(wd_a));
  dpbr_fabric_port #(.AW(8), .DW(16), .INV(4'hf)) u_pb (.clk_i(clk), .pclk_o(pclk_b),
    .en_o(en_b), .we_o(we_b), .orst_o(orst_b), .addr_o(addr_b), .data_o(wd_b));

  // Port B runs with every control pin inverted
  dpbr_top #(.B_LOG2W(4), .B_INV(4'hf)) u_dut (
    .CLK_I(clk), .RESET_I(rst),
    .PCLK_A_I(pclk_a), .EN_A_I(en_a), .WE_A_I(we_a), .ORST_A_I(orst_a), .ADDR_A_I(addr_a),
    .WRITE_DATA_IN_A_I(wd_a), .DOUT_A_O(dout_a),
    .PCLK_B_I(pclk_b), .EN_B_I(en_b), .WE_B_I(we_b), .ORST_B_I(orst_b), .ADDR_B_I(addr_b),
    .WRITE_DATA_IN_B_I(wd_b), .DOUT_B_O(dout_b));

  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic tally_and_finish();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  // Watchdog well beyond the expected 151 cycles
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    rst = 1'b1;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    `CHK(dout_a, 4'h0)
    // Four x4 writes fill one x16 word
    for (int i = 0; i < 4; i++) begin
      u_pa.access(1'b1, 1'b1, 1'b0, 10'(i), 4'(i + 1));
      `CHK(dout_a, 4'(i + 1))
    end
    u_pb.access(1'b1, 1'b0, 1'b0, 8'h00, 16'h0000);
    `CHK(dout_b, 16'h4321)
    u_pb.access(1'b1, 1'b1, 1'b0, 8'h01, 16'habcd);
    `CHK(dout_b, 16'habcd)
    // Narrow reads of the wide word, low nibble first
    for (int i = 0; i < 4; i++) begin
      u_pa.access(1'b1, 1'b0, 1'b0, 10'(4 + i), 4'h0);
      `CHK(dout_a, 4'(16'habcd >> (4 * i)))
    end
    // Disabled port ignores write and output reset
    u_pa.access(1'b0, 1'b1, 1'b1, 10'h004, 4'h0);
    `CHK(dout_a, 4'ha)
    u_pa.access(1'b1, 1'b0, 1'b0, 10'h004, 4'h0);
    `CHK(dout_a, 4'hd)
    // Output reset together with a write
    u_pa.access(1'b1, 1'b1, 1'b1, 10'h005, 4'h7);
    `CHK(dout_a, 4'h0)
    u_pb.access(1'b1, 1'b0, 1'b0, 8'h01, 16'h0000);
    `CHK(dout_b, 16'hab7d)
    u_pb.access(1'b1, 1'b1, 1'b0, 8'h02, 16'h1110);
    `CHK(dout_b, 16'h1110)
    // Output reset on B while A writes the word B addresses; B does not write
    fork
      u_pa.access(1'b1, 1'b1, 1'b0, 10'h008, 4'h5);
      u_pb.access(1'b1, 1'b0, 1'b1, 8'h02, 16'h0000);
    join
    `CHK(dout_b, 16'h0000)
    `CHK(dout_a, 4'h5)
    u_pb.access(1'b1, 1'b0, 1'b0, 8'h02, 16'h0000);
    `CHK(dout_b, 16'h1115)
    repeat (10) @(posedge clk);
    `CHK(dout_b, 16'h1115)
    `CHK(dout_a, 4'h5)
    tally_and_finish();
  end
endmodule : test_dual_port_block_ram

`default_nettype wire
